// ===== rtl/cpw_pkg.sv
// constants shared by the combined pwm control block: offsets, masks, reset values, bit positions
package cpw_pkg;

   // register byte offsets on the ahb-lite bus
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_FCR = 8'h04;
   localparam logic [7:0] OFS_OEN = 8'h08;
   localparam logic [7:0] OFS_OCTL = 8'h0c;
   localparam logic [7:0] OFS_SYNC = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;

   // reset and standby values
   localparam logic [7:0] RST_MODE = 8'h80;
   localparam logic [7:0] RST_FCR = 8'hc0;
   localparam logic [7:0] RST_OEN = 8'hff;
   localparam logic [7:0] RST_OCTL = 8'hff;
   localparam logic [7:0] RST_SYNC = 8'h00;

   // bits that always read as one
   localparam logic [7:0] FIX_MODE = 8'h80;
   localparam logic [7:0] FIX_FCR = 8'hc0;
   localparam logic [7:0] FIX_OEN = 8'hc0;
   localparam logic [7:0] FIX_OCTL = 8'hec;

   // bits that software may change
   localparam logic [7:0] MASK_MODE = 8'h19;
   localparam logic [7:0] MASK_FCR = 8'h3f;
   localparam logic [7:0] MASK_OEN = 8'h3f;
   localparam logic [7:0] MASK_OCTL = 8'h13;
   localparam logic [7:0] MASK_SYNC = 8'h1f;

   // enable bits that an external trigger clears
   localparam logic [7:0] OEN_TRIG_CLR = 8'h3f;

   // timer mode register bits
   localparam int BIT_CH0_PWM = 0;
   localparam int BIT_CH3_PWM = 3;
   localparam int BIT_CH4_PWM = 4;

   // function control register fields
   localparam int FCR_BUF_A3 = 0;
   localparam int FCR_BUF_B3 = 1;
   localparam int FCR_BUF_A4 = 2;
   localparam int FCR_BUF_B4 = 3;
   localparam int FCR_CMB_LO = 4;
   localparam int FCR_CMB_HI = 5;

   // output master enable bits, also the pin index inside the block
   localparam int OEN_A3 = 0;
   localparam int OEN_A4 = 1;
   localparam int OEN_B4 = 2;
   localparam int OEN_B3 = 3;
   localparam int OEN_XA4 = 4;
   localparam int OEN_XB4 = 5;
   localparam int NUM_PINS = 6;

   // output control bits
   localparam int OCTL_OLS3 = 0;
   localparam int OCTL_OLS4 = 1;
   localparam int OCTL_TRIG_DIS = 4;

   // counter sync bits
   localparam int SYNC_CH3 = 3;
   localparam int SYNC_CH4 = 4;

   // combination mode codes
   localparam logic [1:0] CMB_NORMAL = 2'h0;
   localparam logic [1:0] CMB_UNDEF = 2'h1;
   localparam logic [1:0] CMB_COMPL = 2'h2;
   localparam logic [1:0] CMB_RSYNC = 2'h3;

endpackage : cpw_pkg

// ===== rtl/cpw_pin_gate.sv
// one gated output pin: master enable, drive request and optional level inversion
`timescale 1ns/1ps
module cpw_pin_gate (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic enable,
   input wire logic drive_req,
   input wire logic wave,
   input wire logic invert,
   output logic pin_out,
   output logic pin_oe
);

   typedef struct packed {
      logic out;
      logic oe;
   } cpw_pin_state_t;

   cpw_pin_state_t s;
   cpw_pin_state_t next_s;

   // pin released to general i/o when the enable is low
   always_comb begin
      next_s = s;
      next_s.out = invert ? ~wave : wave;
      next_s.oe = enable & drive_req;
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '{out: 1'b0, oe: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign pin_out = s.out;
   assign pin_oe = s.oe;

endmodule : cpw_pin_gate

// ===== rtl/cpw_ctrl.sv
// combined pwm mode select, function control and output master enable with ahb-lite slave
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
// What this block does
// - bit 0 of the timer mode register picks normal (0) or pwm (1) operation for channel 0 and resets to 0.
// - in channel 0 pwm mode its first compare pin goes high on a match with compare a and low on compare b.
// - the function control register loads c0 on reset and on standby and is otherwise read and write.
// - bits 7 and 6 of the function control and output enable registers ignore writes and read as one.
// - bits 5:4 of function control pick normal (00), complementary (10) or reset-synchronised (11) pwm.
// - while a combined mode is selected the channel 3 and 4 pwm select bits have no effect.
// - the channel 3 and 4 counter sync bits stay in effect in both combined modes.
// - function control bits 3 to 0 turn on buffering of compare b4, a4, b3 and a3 when set.
// - the output master enable register loads ff on reset and on standby so all outputs start enabled.
// - enable bits 5 and 4 gate the two channel 4 complementary pins; at 0 the pin is plain i/o.
// - enable bits 3 and 2 gate compare pin b of channels 3 and 4; at 0 the pin is plain i/o.
// - with the trigger disable bit at 0 a channel 1 capture a event in either combined mode clears the enable bits to 0.
// - the trigger disable and the output level bits act only in the two combined modes.
// - channel 3 and 4 counters count up and down in complementary mode and only up otherwise.
module cpw_ctrl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic standby,
   input wire logic ch1_capture_a,
   input wire logic ch0_match_a,
   input wire logic ch0_match_b,
   input wire logic ch3_out_a_wave,
   input wire logic ch4_out_a_wave,
   input wire logic ch3_out_b_wave,
   input wire logic ch4_out_b_wave,
   input wire logic ch4_comp_a_wave,
   input wire logic ch4_comp_b_wave,
   input wire logic ch3_io_drive_a,
   input wire logic ch4_io_drive_a,
   input wire logic ch3_io_drive_b,
   input wire logic ch4_io_drive_b,
   output logic ch0_out_a_pin,
   output logic ch0_out_a_oe,
   output logic ch3_out_a_pin,
   output logic ch3_out_a_oe,
   output logic ch4_out_a_pin,
   output logic ch4_out_a_oe,
   output logic ch3_out_b_pin,
   output logic ch3_out_b_oe,
   output logic ch4_out_b_pin,
   output logic ch4_out_b_oe,
   output logic ch4_comp_out_a_pin,
   output logic ch4_comp_out_a_oe,
   output logic ch4_comp_out_b_pin,
   output logic ch4_comp_out_b_oe,
   output logic ch0_pwm_mode,
   output logic ch3_pwm_mode,
   output logic ch4_pwm_mode,
   output logic complementary_mode,
   output logic reset_sync_mode,
   output logic ch34_count_updown,
   output logic ch3_sync_active,
   output logic ch4_sync_active,
   output logic buffer_sel_a_ch3,
   output logic buffer_sel_b_ch3,
   output logic buffer_sel_a_ch4,
   output logic buffer_sel_b_ch4
);

   typedef struct packed {
      logic dp_valid;
      logic dp_write;
      logic [7:0] dp_addr;
      logic [7:0] mode;
      logic [7:0] fcr;
      logic [7:0] oen;
      logic [7:0] octl;
      logic [7:0] sync;
      logic ch0_pin;
      logic ch0_oe;
   } cpw_state_t;

   cpw_state_t s;
   cpw_state_t next_s;
   logic combined;
   logic trig_fire;
   logic [7:0] stat;
   logic [cpw_pkg::NUM_PINS-1:0] pin_wave;
   logic [cpw_pkg::NUM_PINS-1:0] pin_req;
   logic [cpw_pkg::NUM_PINS-1:0] pin_inv;
   logic [cpw_pkg::NUM_PINS-1:0] pin_out;
   logic [cpw_pkg::NUM_PINS-1:0] pin_oe;

   // merge a write into the writable bits only
   function automatic logic [7:0] wr_merge(input logic [7:0] old, input logic [7:0] wdata, input logic [7:0] mask);
      wr_merge = (old & ~mask) | (wdata & mask);
   endfunction : wr_merge

   // true for either combined pwm mode; the undefined code acts as normal
   function automatic logic is_combined(input logic [1:0] cmb);
      is_combined = (cmb == cpw_pkg::CMB_COMPL) || (cmb == cpw_pkg::CMB_RSYNC);
   endfunction : is_combined

   // read value for one offset, fixed ones merged in, unmapped reads zero
   function automatic logic [7:0] rd_value(input logic [7:0] addr, input cpw_state_t st, input logic [7:0] sv);
      if (addr == cpw_pkg::OFS_MODE) begin
         rd_value = st.mode | cpw_pkg::FIX_MODE;
      end else if (addr == cpw_pkg::OFS_FCR) begin
         rd_value = st.fcr | cpw_pkg::FIX_FCR;
      end else if (addr == cpw_pkg::OFS_OEN) begin
         rd_value = st.oen | cpw_pkg::FIX_OEN;
      end else if (addr == cpw_pkg::OFS_OCTL) begin
         rd_value = st.octl | cpw_pkg::FIX_OCTL;
      end else if (addr == cpw_pkg::OFS_SYNC) begin
         rd_value = st.sync & cpw_pkg::MASK_SYNC;
      end else if (addr == cpw_pkg::OFS_STAT) begin
         rd_value = sv;
      end else begin
         rd_value = 8'h00;
      end
   endfunction : rd_value

   // mode decode from the function control register
   assign combined = is_combined(s.fcr[cpw_pkg::FCR_CMB_HI:cpw_pkg::FCR_CMB_LO]);
   assign complementary_mode = (s.fcr[cpw_pkg::FCR_CMB_HI:cpw_pkg::FCR_CMB_LO] == cpw_pkg::CMB_COMPL);
   assign reset_sync_mode = (s.fcr[cpw_pkg::FCR_CMB_HI:cpw_pkg::FCR_CMB_LO] == cpw_pkg::CMB_RSYNC);
   assign ch34_count_updown = complementary_mode;
   assign trig_fire = ch1_capture_a & ~s.octl[cpw_pkg::OCTL_TRIG_DIS] & combined;
   assign stat = {4'h0, ~s.octl[cpw_pkg::OCTL_TRIG_DIS] & combined, ch34_count_updown, reset_sync_mode,
                  complementary_mode};

   // per-channel mode outputs
   assign ch0_pwm_mode = s.mode[cpw_pkg::BIT_CH0_PWM];
   assign ch3_pwm_mode = s.mode[cpw_pkg::BIT_CH3_PWM] & ~combined;
   assign ch4_pwm_mode = s.mode[cpw_pkg::BIT_CH4_PWM] & ~combined;
   assign ch3_sync_active = s.sync[cpw_pkg::SYNC_CH3];
   assign ch4_sync_active = s.sync[cpw_pkg::SYNC_CH4];
   assign buffer_sel_a_ch3 = s.fcr[cpw_pkg::FCR_BUF_A3];
   assign buffer_sel_b_ch3 = s.fcr[cpw_pkg::FCR_BUF_B3];
   assign buffer_sel_a_ch4 = s.fcr[cpw_pkg::FCR_BUF_A4];
   assign buffer_sel_b_ch4 = s.fcr[cpw_pkg::FCR_BUF_B4];

   // bus answers: zero wait, always okay, read data in the data phase
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = (s.dp_valid && !s.dp_write) ? {24'h000000, rd_value(s.dp_addr, s, stat)} : 32'h00000000;

   // next state: bus phases, register writes, trigger clear, channel 0 pin, standby
   always_comb begin
      next_s = s;
      if (hready) begin
         next_s.dp_valid = hsel & htrans[1];
         next_s.dp_write = hwrite;
         next_s.dp_addr = haddr[7:0];
      end
      if (s.dp_valid && s.dp_write) begin
         if (s.dp_addr == cpw_pkg::OFS_MODE) begin
            next_s.mode = wr_merge(s.mode, hwdata[7:0], cpw_pkg::MASK_MODE);
         end else if (s.dp_addr == cpw_pkg::OFS_FCR) begin
            next_s.fcr = wr_merge(s.fcr, hwdata[7:0], cpw_pkg::MASK_FCR);
         end else if (s.dp_addr == cpw_pkg::OFS_OEN) begin
            next_s.oen = wr_merge(s.oen, hwdata[7:0], cpw_pkg::MASK_OEN);
         end else if (s.dp_addr == cpw_pkg::OFS_OCTL) begin
            next_s.octl = wr_merge(s.octl, hwdata[7:0], cpw_pkg::MASK_OCTL);
         end else if (s.dp_addr == cpw_pkg::OFS_SYNC) begin
            next_s.sync = wr_merge(s.sync, hwdata[7:0], cpw_pkg::MASK_SYNC);
         end
      end
      // hardware clear applied after the write so it wins
      if (trig_fire) begin
         next_s.oen = next_s.oen & ~cpw_pkg::OEN_TRIG_CLR;
      end
      // channel 0 pwm pin, compare b wins a tie
      next_s.ch0_oe = s.mode[cpw_pkg::BIT_CH0_PWM];
      if (!s.mode[cpw_pkg::BIT_CH0_PWM]) begin
         next_s.ch0_pin = 1'b0;
      end else if (ch0_match_b) begin
         next_s.ch0_pin = 1'b0;
      end else if (ch0_match_a) begin
         next_s.ch0_pin = 1'b1;
      end
      // standby loads the reset values
      if (standby) begin
         next_s.mode = cpw_pkg::RST_MODE;
         next_s.fcr = cpw_pkg::RST_FCR;
         next_s.oen = cpw_pkg::RST_OEN;
         next_s.octl = cpw_pkg::RST_OCTL;
         next_s.sync = cpw_pkg::RST_SYNC;
         next_s.ch0_pin = 1'b0;
         next_s.ch0_oe = 1'b0;
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '{dp_valid: 1'b0, dp_write: 1'b0, dp_addr: 8'h00, mode: cpw_pkg::RST_MODE,
                fcr: cpw_pkg::RST_FCR, oen: cpw_pkg::RST_OEN, octl: cpw_pkg::RST_OCTL,
                sync: cpw_pkg::RST_SYNC, ch0_pin: 1'b0, ch0_oe: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign ch0_out_a_pin = s.ch0_pin;
   assign ch0_out_a_oe = s.ch0_oe;

   // channel 3/4 pin sources, index equals the enable bit position
   assign pin_wave = {ch4_comp_b_wave, ch4_comp_a_wave, ch3_out_b_wave, ch4_out_b_wave, ch4_out_a_wave,
                      ch3_out_a_wave};
   assign pin_req = {combined, combined, combined | ch3_io_drive_b, combined | ch4_io_drive_b,
                     combined | ch4_pwm_mode | ch4_io_drive_a, combined | ch3_pwm_mode | ch3_io_drive_a};
   // output level select only inverts in the combined modes
   assign pin_inv = {{3{combined & ~s.octl[cpw_pkg::OCTL_OLS3]}}, {3{combined & ~s.octl[cpw_pkg::OCTL_OLS4]}}};

   // master enable gating of each pin
   for (genvar i = 0; i < cpw_pkg::NUM_PINS; i++) begin : g_pin
      cpw_pin_gate u_gate (
         .hclk(hclk),
         .hresetn(hresetn),
         .enable(s.oen[i]),
         .drive_req(pin_req[i]),
         .wave(pin_wave[i]),
         .invert(pin_inv[i]),
         .pin_out(pin_out[i]),
         .pin_oe(pin_oe[i])
      );
   end

   assign ch3_out_a_pin = pin_out[cpw_pkg::OEN_A3];
   assign ch3_out_a_oe = pin_oe[cpw_pkg::OEN_A3];
   assign ch4_out_a_pin = pin_out[cpw_pkg::OEN_A4];
   assign ch4_out_a_oe = pin_oe[cpw_pkg::OEN_A4];
   assign ch4_out_b_pin = pin_out[cpw_pkg::OEN_B4];
   assign ch4_out_b_oe = pin_oe[cpw_pkg::OEN_B4];
   assign ch3_out_b_pin = pin_out[cpw_pkg::OEN_B3];
   assign ch3_out_b_oe = pin_oe[cpw_pkg::OEN_B3];
   assign ch4_comp_out_a_pin = pin_out[cpw_pkg::OEN_XA4];
   assign ch4_comp_out_a_oe = pin_oe[cpw_pkg::OEN_XA4];
   assign ch4_comp_out_b_pin = pin_out[cpw_pkg::OEN_XB4];
   assign ch4_comp_out_b_oe = pin_oe[cpw_pkg::OEN_XB4];

   // checks on the block's own behaviour
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_ch0_normal_off: assert property (!s.mode[0] |=> !ch0_out_a_oe && !ch0_out_a_pin)
      else $error("channel 0 pin driven outside pwm mode");
   a_ch0_high_on_a: assert property (s.mode[0] && !standby && ch0_match_a && !ch0_match_b
      |=> ch0_out_a_pin && ch0_out_a_oe)
      else $error("channel 0 pin not high after compare a");
   a_fcr_standby_load: assert property (standby |=> s.fcr == 8'hc0)
      else $error("function control not c0 after standby");
   a_fixed_ones_read: assert property (s.dp_valid && !s.dp_write
      && (s.dp_addr == 8'h04 || s.dp_addr == 8'h08) |-> hrdata[7:6] == 2'h3)
      else $error("reserved bits not read as one");
   a_pwm_sel_ignored: assert property (combined |-> !ch3_pwm_mode && !ch4_pwm_mode)
      else $error("channel 3/4 pwm select active in combined mode");
   a_sync_kept: assert property (ch3_sync_active == s.sync[3] && ch4_sync_active == s.sync[4])
      else $error("sync select lost");
   a_buffer_follow: assert property (s.dp_valid && s.dp_write && s.dp_addr == 8'h04 && !standby
      |=> {buffer_sel_b_ch4, buffer_sel_a_ch4, buffer_sel_b_ch3, buffer_sel_a_ch3} == $past(hwdata[3:0]))
      else $error("buffer selects do not follow write");
   a_oen_standby_load: assert property (standby |=> s.oen == 8'hff)
      else $error("output enable not ff after standby");
   a_comp_pin_gated: assert property (!s.oen[5] || !s.oen[4] |=> (!ch4_comp_out_b_oe || $past(s.oen[5]))
      && (!ch4_comp_out_a_oe || $past(s.oen[4])))
      else $error("complementary pin driven while disabled");
   a_b_pin_gated: assert property (!s.oen[3] |=> !ch3_out_b_oe)
      else $error("channel 3 pin b driven while disabled");
   a_trigger_clears: assert property (ch1_capture_a && !s.octl[4] && combined && !standby
      |=> s.oen[5:0] == 6'h00)
      else $error("trigger did not clear enables");
   a_trigger_normal: assert property (ch1_capture_a && !combined && !standby && !(s.dp_valid && s.dp_write)
      |=> $stable(s.oen))
      else $error("trigger acted outside combined mode");
   a_updown_mode: assert property (ch34_count_updown == (s.fcr[5:4] == 2'h2))
      else $error("count direction wrong for mode");

   // channel 0 low on compare b, b also wins a tie
   a_ch0_low_b: assert property (s.mode[0] && !standby && ch0_match_b
      |=> !ch0_out_a_pin)
      else $error("channel 0 pin not low after compare b");

   // mode register and channel 0 pin back to rest after standby
   a_mode_standby_load: assert property (standby |=> s.mode == 8'h80 && !ch0_out_a_oe)
      else $error("mode register not at rest after standby");

   // channel 4 pin b released while its enable is low
   a_b4_pin_gated: assert property (!s.oen[2] |=> !ch4_out_b_oe)
      else $error("channel 4 pin b driven while disabled");

   // complementary pins only driven in the combined modes
   a_comp_off_normal: assert property (!combined |=> !ch4_comp_out_a_oe && !ch4_comp_out_b_oe)
      else $error("complementary pin driven outside combined mode");

   // trigger has no effect while the disable bit is set
   a_trigger_masked: assert property (ch1_capture_a && s.octl[4] && !standby && !(s.dp_valid && s.dp_write)
      |=> $stable(s.oen))
      else $error("trigger acted while disabled");

endmodule : cpw_ctrl

// ===== dv/cpw_pin_load.sv
// far-side load on the timer output pins: pulled-up lines read by outside circuitry
`timescale 1ns/1ps
module cpw_pin_load #(
   parameter int N = 7
) (
   input wire logic [N-1:0] pin,
   input wire logic [N-1:0] oe,
   output logic [N-1:0] level
);
   // a released pin is plain i/o and settles to the pull-up, a driven pin shows the block's level
   always_comb begin
      for (int i = 0; i < N; i++) begin
         level[i] = (oe[i] === 1'b1) ? pin[i] : 1'b1;
      end
   end
endmodule : cpw_pin_load

// ===== dv/combined_pwm_mode_output_control_test.sv
// self-checking bench for the combined pwm control block
`timescale 1ns/1ps
module combined_pwm_mode_output_control_test;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic standby = 1'b0;
   logic [2:0] strb = 3'h0;
   logic [5:0] wave = 6'h0;
   logic [3:0] io_drv = 4'h0;
   logic hreadyout, hresp;
   logic [31:0] hrdata, tmp;
   logic [6:0] pin, oe, level;
   logic [2:0] pwm, cmode;
   logic [1:0] sync;
   logic [3:0] buf_sel;
   int errors = 0;
   int checked = 0;

   // free-running 50 MHz clock
   always #10 hclk = ~hclk;

   cpw_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .standby(standby), .ch1_capture_a(strb[0]), .ch0_match_a(strb[1]), .ch0_match_b(strb[2]),
      .ch3_out_a_wave(wave[0]), .ch4_out_a_wave(wave[1]), .ch3_out_b_wave(wave[2]), .ch4_out_b_wave(wave[3]),
      .ch4_comp_a_wave(wave[4]), .ch4_comp_b_wave(wave[5]), .ch3_io_drive_a(io_drv[0]),
      .ch4_io_drive_a(io_drv[1]), .ch3_io_drive_b(io_drv[2]), .ch4_io_drive_b(io_drv[3]),
      .ch0_out_a_pin(pin[0]), .ch0_out_a_oe(oe[0]), .ch3_out_a_pin(pin[1]), .ch3_out_a_oe(oe[1]),
      .ch4_out_a_pin(pin[2]), .ch4_out_a_oe(oe[2]), .ch3_out_b_pin(pin[3]), .ch3_out_b_oe(oe[3]),
      .ch4_out_b_pin(pin[4]), .ch4_out_b_oe(oe[4]), .ch4_comp_out_a_pin(pin[5]), .ch4_comp_out_a_oe(oe[5]),
      .ch4_comp_out_b_pin(pin[6]), .ch4_comp_out_b_oe(oe[6]), .ch0_pwm_mode(pwm[0]), .ch3_pwm_mode(pwm[1]),
      .ch4_pwm_mode(pwm[2]), .complementary_mode(cmode[0]), .reset_sync_mode(cmode[1]),
      .ch34_count_updown(cmode[2]), .ch3_sync_active(sync[0]), .ch4_sync_active(sync[1]),
      .buffer_sel_a_ch3(buf_sel[0]), .buffer_sel_b_ch3(buf_sel[1]), .buffer_sel_a_ch4(buf_sel[2]),
      .buffer_sel_b_ch4(buf_sel[3]));

   cpw_pin_load #(.N(7)) load (.pin(pin), .oe(oe), .level(level));

   // compare and count
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // one single ahb-lite transfer, optional capture strobe during its data phase
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d, input logic trig,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      strb <= {2'b00, trig};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      strb <= 3'h0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, {24'h0, d}, 1'b0, tmp);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      bus(a, 1'b0, 32'h0, 1'b0, tmp);
      check(name, tmp, {24'h0, exp});
   endtask : rd

   // let register and pin stages land
   task automatic settle();
      repeat (2) @(posedge hclk);
   endtask : settle

   // one-cycle strobe, then one edge for the pin stage
   task automatic pulse(input logic [2:0] m);
      @(posedge hclk);
      strb <= m;
      @(posedge hclk);
      strb <= 3'h0;
      @(posedge hclk);
   endtask : pulse

   task automatic t_reset();
      rd(cpw_pkg::OFS_FCR, cpw_pkg::RST_FCR, "fcr reset");
      rd(cpw_pkg::OFS_OEN, cpw_pkg::RST_OEN, "oen reset");
      rd(cpw_pkg::OFS_MODE, cpw_pkg::RST_MODE, "mode reset");
      rd(8'h18, 8'h00, "unmapped read");
      check("ch0 pwm reset", pwm[0], 1'b0);
      check("okay response", hresp, 1'b0);
      $display("done reset values");
   endtask : t_reset

   task automatic t_fixed();
      wr(cpw_pkg::OFS_FCR, 8'h00);
      rd(cpw_pkg::OFS_FCR, 8'hc0, "fcr fixed bits");
      wr(cpw_pkg::OFS_OEN, 8'h00);
      rd(cpw_pkg::OFS_OEN, 8'hc0, "oen fixed bits");
      wr(cpw_pkg::OFS_OEN, 8'hff);
      // walk each buffer select bit on its own
      for (int i = 0; i < 4; i++) begin
         wr(cpw_pkg::OFS_FCR, 8'h01 << i);
         rd(cpw_pkg::OFS_FCR, 8'hc0 | (8'h01 << i), "fcr rw");
         check("buffer select", buf_sel, 4'h1 << i);
      end
      $display("done fixed bits and buffering");
   endtask : t_fixed

   task automatic t_modes();
      logic [1:0] c;
      wr(cpw_pkg::OFS_MODE, 8'h18);
      wr(cpw_pkg::OFS_SYNC, 8'h08);
      for (int i = 0; i < 4; i++) begin
         c = i[1:0];
         wr(cpw_pkg::OFS_FCR, {2'b00, c, 4'h0});
         settle();
         check("mode outputs", cmode, {c == 2'h2, c == 2'h3, c == 2'h2});
         check("ch3 ch4 pwm", pwm[2:1], {2{~c[1]}});
         check("sync active", sync, 2'b01);
      end
      wr(cpw_pkg::OFS_FCR, 8'h00);
      wr(cpw_pkg::OFS_MODE, 8'h01);
      settle();
      check("ch0 pwm on", {pwm[0], oe[0]}, 2'b11);
      pulse(3'h2);
      check("ch0 high on match a", level[0], 1'b1);
      pulse(3'h4);
      check("ch0 low on match b", level[0], 1'b0);
      $display("done modes and channel 0");
   endtask : t_modes

   task automatic t_gate();
      wr(cpw_pkg::OFS_FCR, 8'h20);
      io_drv <= 4'hf;
      wave <= 6'h00;
      for (int b = 0; b < 6; b++) begin
         wr(cpw_pkg::OFS_OEN, 8'h3f & ~(8'h01 << b));
         settle();
         check("gated oe", oe[6:1], {b != 5, b != 4, b != 2, b != 3, b != 1, b != 0});
         check("gated level", level[6:1], {b == 5, b == 4, b == 2, b == 3, b == 1, b == 0});
      end
      wr(cpw_pkg::OFS_OEN, 8'hff);
      wr(cpw_pkg::OFS_OCTL, 8'hfc);
      settle();
      check("inverted in combined", pin[6:1], 6'h3f);
      wr(cpw_pkg::OFS_FCR, 8'h00);
      settle();
      check("plain in normal", pin[6:1], 6'h00);
      check("drive in normal", oe[6:1], 6'h0f);
      $display("done output gating");
   endtask : t_gate

   task automatic t_trig();
      wr(cpw_pkg::OFS_OCTL, 8'hef);
      pulse(3'h1);
      rd(cpw_pkg::OFS_OEN, 8'hff, "trigger in normal");
      wr(cpw_pkg::OFS_FCR, 8'h20);
      pulse(3'h1);
      rd(cpw_pkg::OFS_OEN, 8'hc0, "trigger clears");
      wr(cpw_pkg::OFS_OEN, 8'hff);
      bus(cpw_pkg::OFS_OEN, 1'b1, 32'hff, 1'b1, tmp);
      rd(cpw_pkg::OFS_OEN, 8'hc0, "clear beats write");
      wr(cpw_pkg::OFS_OCTL, 8'hff);
      wr(cpw_pkg::OFS_OEN, 8'hff);
      pulse(3'h1);
      rd(cpw_pkg::OFS_OEN, 8'hff, "trigger disabled");
      $display("done external trigger");
   endtask : t_trig

   task automatic t_standby();
      wr(cpw_pkg::OFS_FCR, 8'h25);
      wr(cpw_pkg::OFS_OEN, 8'h00);
      wr(cpw_pkg::OFS_MODE, 8'h01);
      @(posedge hclk);
      standby <= 1'b1;
      @(posedge hclk);
      standby <= 1'b0;
      rd(cpw_pkg::OFS_FCR, 8'hc0, "fcr standby");
      rd(cpw_pkg::OFS_OEN, 8'hff, "oen standby");
      rd(cpw_pkg::OFS_MODE, 8'h80, "mode standby");
      $display("done standby");
   endtask : t_standby

   // verdict and end of run
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   // main sequence
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_fixed();
      t_modes();
      t_gate();
      t_trig();
      t_standby();
      end_sim();
   end

   // watchdog, far beyond the 150 or so cycles the tests need
   initial begin
      repeat (20000) @(posedge hclk);
      errors++;
      end_sim();
   end
endmodule : combined_pwm_mode_output_control_test
